/* File: rtl/p0irq_top.sv */
// Port 0 external interrupt pending register with enable and irq.
// Assumes Avalon-MM master on core_clk and synchronous pins.
//
// Functional notes
// [R1] Read returns one per pending line
// [R2] Write zero clears flag, one keeps it
// [R3] Lines sit at bits 0,1,3,4,5,6
// [R4] Pending register decoded at index e6
// [R5] Reset clears flags; bits 2,7 read zero
// [R6] Falling edge on input pin sets flag
// [R7] Flag requests interrupt only when enabled
`timescale 1ns/1ps
`default_nettype none
`include "p0irq_defs.svh"
module p0irq_top #(
  parameter int LINES = `P0IRQ_LINES
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Avalon-MM slave
  input  wire logic [9:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  // External lines
  input  wire logic [LINES-1:0] ext_line_pin,
  // Interrupt
  output logic                  ext_irq
);

  if (LINES != `P0IRQ_LINES) begin : g_bad_lines
    $error("p0irq_top: the bit map serves exactly six lines");
  end

  // ========================================================
  // Bit map
  localparam int POS [0:5] = '{`P0IRQ_BIT_L0, `P0IRQ_BIT_L1,
    `P0IRQ_BIT_L2, `P0IRQ_BIT_L3, `P0IRQ_BIT_L4, `P0IRQ_BIT_L5};

  function automatic logic [7:0] to_reg(input logic [5:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 6; i++) begin
      r[POS[i]] = v[i]; // [R3]
    end
    return r;
  endfunction

  function automatic logic [5:0] to_lines(input logic [7:0] r);
    logic [5:0] v;
    v = 6'h00;
    for (int i = 0; i < 6; i++) begin
      v[i] = r[POS[i]]; // [R3]
    end
    return v;
  endfunction

  // ========================================================
  // Signals
  logic [5:0]  pend;
  logic [5:0]  next_pend;
  logic [5:0]  en;
  logic [5:0]  next_en;
  logic [5:0]  mode;
  logic [5:0]  next_mode;
  logic        next_irq;
  logic [5:0]  fall;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rd_value;
  logic [7:0]  pend_reg;
  logic [7:0]  idx;
  logic        aligned;
  logic        hit_pend;
  logic        hit_en;
  logic        hit_mode;
  logic        hit_clr;
  logic        hit_stat;
  logic        wr_ok;
  logic [5:0]  wr_lines;
  logic [5:0]  clr;

  // ========================================================
  // Submodules
  p0irq_avs u_avs (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .rd_value        (rd_value),
    .wr_fire         (wr_fire),
    .rd_fire         (rd_fire)
  );

  p0irq_fall #(.LINES(LINES)) u_fall (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .pin        (ext_line_pin),
    .input_mode (mode),
    .fall       (fall)
  );

  // ========================================================
  // Address decode
  always_comb begin
    idx      = avs_address[9:`P0IRQ_IDX_LSB];
    aligned  = (avs_address[1:0] == `P0IRQ_ALIGN);
    hit_pend = 1'b0;
    hit_en   = 1'b0;
    hit_mode = 1'b0;
    hit_clr  = 1'b0;
    hit_stat = 1'b0;
    if (!aligned) begin
      hit_pend = 1'b0;
    end else if (idx == `P0IRQ_IDX_PEND) begin
      hit_pend = 1'b1; // [R4]
    end else if (idx == `P0IRQ_IDX_EN) begin
      hit_en = 1'b1;
    end else if (idx == `P0IRQ_IDX_MODE) begin
      hit_mode = 1'b1;
    end else if (idx == `P0IRQ_IDX_CLR) begin
      hit_clr = 1'b1;
    end else if (idx == `P0IRQ_IDX_STAT) begin
      hit_stat = 1'b1;
    end
    wr_ok    = wr_fire && avs_byteenable[0];
    wr_lines = to_lines(avs_writedata[7:0]);
    pend_reg = to_reg(pend);
    rd_value = 32'h0000_0000;
    if (hit_pend || hit_stat) begin
      rd_value[7:0] = pend_reg; // [R1] [R5]
    end else if (hit_en) begin
      rd_value[7:0] = to_reg(en);
    end else if (hit_mode) begin
      rd_value[7:0] = to_reg(mode);
    end
  end

  // ========================================================
  // Pending flags, enables and mode
  always_comb begin
    clr = 6'h00;
    if (wr_ok && hit_pend) begin
      clr = ~wr_lines; // [R2]
    end else if (wr_ok && hit_clr) begin
      clr = wr_lines;
    end
    next_pend = fall | (pend & ~clr); // [R6]
    next_en   = (wr_ok && hit_en) ? wr_lines : en;
    next_mode = (wr_ok && hit_mode) ? wr_lines : mode;
    next_irq  = |(next_pend & next_en); // [R7]
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend    <= `P0IRQ_PEND_RST; // [R5]
      en      <= `P0IRQ_EN_RST;
      mode    <= `P0IRQ_MODE_RST;
      ext_irq <= 1'b0;
    end else begin
      pend    <= next_pend;
      en      <= next_en;
      mode    <= next_mode;
      ext_irq <= next_irq;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic pend_wr;
  logic pend_rd;
  assign pend_wr = wr_ok && hit_pend;
  assign pend_rd = rd_fire && hit_pend;

  logic stat_rd;
  logic miss_rd;
  assign stat_rd = rd_fire && hit_stat;
  assign miss_rd = rd_fire && !(hit_pend || hit_en || hit_mode || hit_stat);

  pend_read_a: assert property ( // [R1]
    pend_rd |-> avs_readdata[7:0] == to_reg($past(pend)))
    else $error("pending read does not show flags");

  clear_zero_a: assert property ( // [R2]
    pend_wr |=> (pend & ~$past(wr_lines) & ~$past(fall)) == 6'h00)
    else $error("write of zero did not clear flag");

  write_one_a: assert property ( // [R2]
    pend_wr |=> ($past(pend) & $past(wr_lines) & ~pend) == 6'h00)
    else $error("write of one changed a flag");

  line2_bit3_a: assert property ( // [R3]
    fall[2] |=> pend_reg[`P0IRQ_BIT_L2] ##1 1'b1)
    else $error("line 2 not seen at bit 3");

  decode_only_a: assert property ( // [R4]
    (wr_fire && !hit_pend && !hit_clr) |=> ($past(pend) & ~pend) == 6'h00)
    else $error("flag cleared by another address");

  unused_zero_a: assert property ( // [R5]
    pend_rd |-> !avs_readdata[`P0IRQ_BIT_UNUSED_LO]
                && !avs_readdata[`P0IRQ_BIT_UNUSED_HI])
    else $error("unused pending bit reads one");

  set_by_edge_a: assert property ( // [R6]
    (pend & ~$past(pend) & ~$past(fall)) == 6'h00)
    else $error("flag set without a falling edge");

  edge_sets_a: assert property ( // [R6]
    (ext_line_pin[0] && mode[0]) ##1 (!ext_line_pin[0] && mode[0])
      |=> pend[0])
    else $error("falling edge on line 0 not caught");

  irq_gate_a: assert property ( // [R7]
    ((pend & en) == 6'h00) [*2] |-> !ext_irq)
    else $error("interrupt without enabled flag");

  irq_rise_a: assert property ( // [R7]
    ((pend & en) != 6'h00) |=> ext_irq || $past(pend_wr || wr_fire))
    else $error("enabled flag raised no interrupt");

  wait_pulse_a: assert property ( // [R1]
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");

  wait_answer_a: assert property ( // [R1]
    (avs_waitrequest && (avs_read || avs_write)) |=> !avs_waitrequest)
    else $error("request not answered after one cycle");

  read_upper_a: assert property ( // [R1]
    rd_fire |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  status_copy_a: assert property ( // [R1]
    stat_rd |-> avs_readdata[7:0] == to_reg($past(pend)))
    else $error("status read does not show flags");

  write_once_a: assert property ( // [R2]
    wr_fire |=> !wr_fire)
    else $error("one write took effect twice");

  clear_reg_a: assert property ( // [R2]
    (wr_ok && hit_clr) |=> (pend & $past(wr_lines) & ~$past(fall)) == 6'h00)
    else $error("clear register left a flag set");

  byte_gate_a: assert property ( // [R2]
    (wr_fire && !avs_byteenable[0]) |=> ($past(pend) & ~pend) == 6'h00)
    else $error("write without lane zero changed a flag");

  unmapped_read_a: assert property ( // [R4]
    miss_rd |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  write_rdata_a: assert property ( // [R4]
    wr_fire |-> avs_readdata == 32'h0000_0000)
    else $error("write left read data behind");

  reset_clear_a: assert property ( // [R5]
    disable iff (1'b0) sys_rst ##1 sys_rst |-> pend == 6'h00 && !ext_irq)
    else $error("reset left a flag or interrupt");

  mode_gate_a: assert property ( // [R6]
    (pend & ~$past(pend) & ~$past(mode)) == 6'h00)
    else $error("flag set on a line not in input mode");

  fall_shape_a: assert property ( // [R6]
    (fall & ~($past(ext_line_pin) & ~ext_line_pin)) == 6'h00)
    else $error("edge pulse without a high to low step");

  mode_write_a: assert property ( // [R6]
    (wr_ok && hit_mode) |=> mode == $past(wr_lines))
    else $error("mode write not stored");

  mode_hold_a: assert property ( // [R6]
    !(wr_ok && hit_mode) |=> $stable(mode))
    else $error("mode changed without a write");

  en_write_a: assert property ( // [R7]
    (wr_ok && hit_en) |=> en == $past(wr_lines))
    else $error("enable write not stored");

  en_hold_a: assert property ( // [R7]
    !(wr_ok && hit_en) |=> $stable(en))
    else $error("enable changed without a write");

  irq_exact_a: assert property ( // [R7]
    ext_irq == |(pend & en))
    else $error("interrupt does not follow enabled flags");

  edge_irq_c: cover property (fall[5] ##1 en[5] ##1 ext_irq);
  clear_c: cover property (pend[0] && pend_wr ##1 !pend[0]);
  race_c: cover property (pend_wr && (fall & ~wr_lines) != 6'h00);
  status_c: cover property (stat_rd && avs_readdata[7:0] != 8'h00);
  clear_reg_c: cover property (wr_ok && hit_clr ##1 pend != 6'h00);

endmodule
`default_nettype wire

/* File: rtl/p0irq_defs.svh */
// Register indices, bit positions and reset values of the port 0
// external interrupt pending block.
// Assumes byte addressing on a 32-bit Avalon-MM bus.
`ifndef P0IRQ_DEFS_SVH
`define P0IRQ_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define P0IRQ_IDX_PEND   8'he6
`define P0IRQ_IDX_EN     8'he3
`define P0IRQ_IDX_MODE   8'hf0
`define P0IRQ_IDX_CLR    8'hf1
`define P0IRQ_IDX_STAT   8'hf2
`define P0IRQ_IDX_LSB    2
`define P0IRQ_ALIGN      2'h0

// ==========================================================
// Line to register bit positions
`define P0IRQ_BIT_L0     0
`define P0IRQ_BIT_L1     1
`define P0IRQ_BIT_L2     3
`define P0IRQ_BIT_L3     4
`define P0IRQ_BIT_L4     5
`define P0IRQ_BIT_L5     6
`define P0IRQ_BIT_UNUSED_LO 2
`define P0IRQ_BIT_UNUSED_HI 7

// ==========================================================
// Reset values
`define P0IRQ_PEND_RST   6'h00
`define P0IRQ_EN_RST     6'h00
`define P0IRQ_MODE_RST   6'h3f
`define P0IRQ_RD_RST     32'h0000_0000
`define P0IRQ_LINES      6

`endif

/* File: rtl/p0irq_pkg.sv */
// Types shared by the port 0 external interrupt pending block.
// Assumes nothing of its surroundings.
package p0irq_pkg;

  // ========================================================
  // Bus handshake state, Gray coded
  typedef enum logic [0:0] {
    P0IRQ_IDLE = 1'b0,
    P0IRQ_ACK  = 1'b1
  } p0irq_bus_st_t;

endpackage

/* File: rtl/p0irq_fall.sv */
// Falling edge detector, one stage per line, gated by input mode.
// Assumes pins are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module p0irq_fall #(
  parameter int LINES = 6
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Pins and mode
  input  wire logic [LINES-1:0] pin,
  input  wire logic [LINES-1:0] input_mode,
  // Edge pulses
  output logic      [LINES-1:0] fall
);

  logic [LINES-1:0] prev;
  logic [LINES-1:0] next_prev;

  if (LINES < 1) begin : g_bad_lines
    $error("p0irq_fall: LINES must be at least one");
  end

  // ========================================================
  // Per line edge detect
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      always_comb begin
        next_prev[g] = pin[g];
        fall[g]      = prev[g] & ~pin[g] & input_mode[g]; // [R6]
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/p0irq_avs.sv */
// Avalon-MM slave handshake with one wait cycle per access.
// Assumes the master holds its request until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module p0irq_avs (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Bus
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  output logic             avs_waitrequest,
  output logic [31:0]      avs_readdata,
  // Register side
  input  wire logic [31:0] rd_value,
  output logic             wr_fire,
  output logic             rd_fire
);

  p0irq_pkg::p0irq_bus_st_t state;
  p0irq_pkg::p0irq_bus_st_t next_state;
  logic                     next_wait;
  logic [31:0]              next_rdata;

  // ========================================================
  // Handshake
  always_comb begin
    next_state = state;
    next_rdata = avs_readdata;
    case (state)
      p0irq_pkg::P0IRQ_IDLE: begin
        if (avs_read || avs_write) begin
          next_state = p0irq_pkg::P0IRQ_ACK;
          next_rdata = avs_read ? rd_value : `P0IRQ_RD_RST;
        end
      end
      default: begin
        next_state = p0irq_pkg::P0IRQ_IDLE;
      end
    endcase
    next_wait = (next_state != p0irq_pkg::P0IRQ_ACK);
    wr_fire   = (state == p0irq_pkg::P0IRQ_ACK) && avs_write;
    rd_fire   = (state == p0irq_pkg::P0IRQ_ACK) && avs_read;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state           <= p0irq_pkg::P0IRQ_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `P0IRQ_RD_RST;
    end else begin
      state           <= next_state;
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_rdata;
    end
  end

endmodule
`default_nettype wire

/* File: verif/p0irq_pins.sv */
// External pin model driving the six port 0 interrupt lines.
// Assumes the bench sets drop just after a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module p0irq_pins (
  // Clock
  input  wire logic       core_clk,
  // Control and pins
  input  wire logic [5:0] drop,
  output logic      [5:0] pin
);
  // ========================================================
  // Idle high; a line only falls after a sampled high cycle
  initial pin = 6'h3f;
  always @(posedge core_clk) begin
    pin <= ~(drop & pin);
  end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the port 0 interrupt pending block.
// Assumes the design files and the pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ========================================================
  // Signals
  logic        core_clk  = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [9:0]  adr       = 10'h000;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdat      = 32'h0000_0000;
  logic [3:0]  be        = 4'hf;
  logic [5:0]  drop      = 6'h00;
  logic [31:0] rdat;
  logic        wreq;
  logic [5:0]  pin;
  logic        irq;
  logic [31:0] got;
  logic [31:0] d;
  logic [5:0]  m;
  logic [5:0]  pend      = 6'h00;
  logic [5:0]  en        = 6'h00;
  int          err_total = 0;
  int          n_checks  = 0;
  int          cyc       = 0;

  always #12.5 core_clk = ~core_clk;

  p0irq_pins pins_u (.core_clk(core_clk), .drop(drop), .pin(pin));
  p0irq_top dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .ext_line_pin(pin), .ext_irq(irq));

  // ========================================================
  // Helpers
  function automatic logic [31:0] to_reg(input logic [5:0] l);
    return {24'h0, 1'b0, l[5:2], 1'b0, l[1:0]};
  endfunction

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] v);
    @(posedge core_clk);
    adr <= a;
    wdat <= v;
    rd <= ~w;
    wr <= w;
    do @(posedge core_clk); while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(got, e);
  endtask

  task automatic fall(input logic [5:0] l);
    @(posedge core_clk);
    drop <= l;
    @(posedge core_clk);
    drop <= 6'h00;
    repeat (3) @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // ========================================================
  // Main sequence
  initial begin
    got = $urandom(32'hedef372d);
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(10'h398, 32'h0);
    rchk(10'h38c, 32'h0);
    rchk(10'h3c0, 32'h7b);
    rchk(10'h3c8, 32'h0);
    rchk(10'h000, 32'h0);
    for (int i = 0; i < 6; i++) begin
      fall(6'h01 << i);
      rchk(10'h398, to_reg(6'h01 << i));
      bus(1'b1, 10'h398, 32'hff ^ to_reg(6'h01 << i));
      rchk(10'h398, 32'h0);
    end
    bus(1'b1, 10'h3c0, to_reg(6'h2a));
    fall(6'h3f);
    rchk(10'h398, to_reg(6'h2a));
    bus(1'b1, 10'h3c0, 32'h7b);
    fall(6'h3f);
    @(posedge core_clk);
    be <= 4'h0;
    bus(1'b1, 10'h398, 32'h0);
    be <= 4'hf;
    bus(1'b1, 10'h39a, 32'h0);
    rchk(10'h398, 32'h7b);
    rchk(10'h3c8, 32'h7b);
    bus(1'b1, 10'h3c4, to_reg(6'h05));
    rchk(10'h398, to_reg(6'h3a));
    rchk(10'h3c4, 32'h0);
    bus(1'b1, 10'h398, 32'h84);
    rchk(10'h398, 32'h0);
    fork
      fall(6'h01);
      bus(1'b1, 10'h398, 32'h0);
    join
    rchk(10'h398, 32'h01);
    pend = 6'h01;
    for (int i = 0; i < 40; i++) begin
      m = 6'($urandom());
      fall(m);
      pend = pend | m;
      en = 6'($urandom());
      bus(1'b1, 10'h38c, to_reg(en));
      rchk(10'h38c, to_reg(en));
      d = $urandom();
      bus(1'b1, 10'h398, d);
      pend = pend & {d[6:3], d[1:0]};
      rchk(10'h398, to_reg(pend));
      check({31'h0, irq}, {31'h0, |(pend & en)});
    end
    fall(6'h3f);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(10'h398, 32'h0);
    check({31'h0, irq}, 32'h0);
    rchk(10'h3c0, 32'h7b);
    rchk(10'h38c, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
